// >>> core/slsc_regs.sv
// Serial link status and lane control register bank with Avalon-MM slave.
// Assumes link status and SYSREF pulses come from logic on mclk; the
// SYNC~ pin and synthesizer lock are asynchronous and synchronised here.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/100ps
module slsc_regs #(
    parameter int LANES = 8
)(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [11:0] avAddress,
    input wire logic avRead,
    input wire logic avWrite,
    input wire logic [31:0] avWriteData,
    input wire logic [3:0] avByteEnable,
    output logic [31:0] avReadData,
    output logic avWaitRequest,
    output logic irq,
    input wire logic linkUp,
    input wire logic syncN,
    input wire logic synthLockedPin,
    input wire logic sysrefRealign,
    input wire logic sysrefPhaseEvent,
    input wire logic [LANES-1:0] baseLanesA,
    input wire logic [LANES-1:0] baseLanesB,
    input wire logic linkAHoldsBoth,
    input wire logic [1:0] digBindB,
    output logic converterAPowerdown,
    output logic converterBPowerdown,
    output logic [1:0] digChanPowerDown,
    output logic serialSubsystemPowerDown,
    output logic slotBValid,
    output logic linkEncoderEnable,
    output logic [slsc_pkg::FORMAT_W-1:0] linkFormatSelect,
    output logic [slsc_pkg::TEST_W-1:0] linkTestPatternSelect,
    output logic [LANES-1:0] laneClkEnA,
    output logic [LANES-1:0] serClkEnA,
    output logic [LANES-1:0] laneClkEnB,
    output logic [LANES-1:0] serClkEnB
);
    // =========================================================
    // Elaboration check
    if (LANES != 8)
    begin : g_bad_lanes
        $error("slsc_regs: spare registers hold exactly 8 lanes");
    end

    // =========================================================
    // Pin synchronisers
    logic syncMeta;
    logic syncStat;
    logic lockMeta;
    logic lockStat;

    // First stages feed only the second stages
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            syncMeta <= 1'b0;
            syncStat <= 1'b0;
            lockMeta <= 1'b0;
            lockStat <= 1'b0;
        end
        else
        begin
            syncMeta <= syncN;
            syncStat <= syncMeta;
            lockMeta <= synthLockedPin;
            lockStat <= lockMeta;
        end
    end

    // =========================================================
    // Bus decode
    function automatic logic hit(input logic [11:0] addr, input logic [9:0] idx);
        hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    logic busReq;
    logic accept;
    logic wrLane0;
    logic [7:0] wdata;

    assign busReq = avRead | avWrite;
    // Write lands at the edge where waitrequest is sampled low
    assign accept = busReq & ~avWaitRequest;
    assign wrLane0 = avWrite & accept & avByteEnable[0];
    assign wdata = avWriteData[7:0];

    // =========================================================
    // Software registers
    logic [7:0] pwrdn;
    logic [7:0] spareA;
    logic [7:0] spareB;
    logic [7:0] irqMask;
    logic [7:0] ctrl;
    logic [7:0] format;
    logic [7:0] next_pwrdn;
    logic [7:0] next_spareA;
    logic [7:0] next_spareB;
    logic [7:0] next_irqMask;
    logic [7:0] next_ctrl;
    logic [7:0] next_format;

    // Reserved bits are masked off so they read as zero
    always_comb
    begin
        next_pwrdn = pwrdn;
        next_spareA = spareA;
        next_spareB = spareB;
        next_irqMask = irqMask;
        next_ctrl = ctrl;
        next_format = format;
        if (wrLane0)
        begin
            if (hit(avAddress, slsc_pkg::IDX_PWRDN))
                next_pwrdn = wdata & slsc_pkg::PWRDN_WMASK;
            if (hit(avAddress, slsc_pkg::IDX_SPARE_A))
                next_spareA = wdata;
            if (hit(avAddress, slsc_pkg::IDX_SPARE_B))
                next_spareB = wdata;
            if (hit(avAddress, slsc_pkg::IDX_IRQ_MASK))
                next_irqMask = wdata & slsc_pkg::STICKY_WMASK;
            if (hit(avAddress, slsc_pkg::IDX_CTRL))
                next_ctrl = wdata & slsc_pkg::CTRL_WMASK;
            if (hit(avAddress, slsc_pkg::IDX_FORMAT))
                next_format = wdata & slsc_pkg::FORMAT_WMASK;
        end
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            pwrdn <= slsc_pkg::PWRDN_RST;
            spareA <= slsc_pkg::SPARE_RST;
            spareB <= slsc_pkg::SPARE_RST;
            irqMask <= slsc_pkg::MASK_RST;
            ctrl <= slsc_pkg::CTRL_RST;
            format <= slsc_pkg::FORMAT_RST;
        end
        else
        begin
            pwrdn <= next_pwrdn;
            spareA <= next_spareA;
            spareB <= next_spareB;
            irqMask <= next_irqMask;
            ctrl <= next_ctrl;
            format <= next_format;
        end
    end

    // =========================================================
    // Sticky alignment flags and interrupt
    logic realignFlag;
    logic alignedFlag;
    logic armed;
    logic next_realignFlag;
    logic next_alignedFlag;
    logic next_armed;
    logic next_irq;
    logic encEn;
    logic encEnPrev;
    logic clrStatus;

    assign encEn = ctrl[slsc_pkg::CTRL_ENC_EN];
    assign clrStatus = wrLane0 & hit(avAddress, slsc_pkg::IDX_STATUS);

    // Clear applied first, so a same-cycle event wins
    always_comb
    begin
        next_realignFlag = realignFlag;
        next_alignedFlag = alignedFlag;
        next_armed = armed;
        if (clrStatus && wdata[slsc_pkg::ST_REALIGN])
            next_realignFlag = 1'b0;
        if (clrStatus && wdata[slsc_pkg::ST_MULTIFRAME_PHASE_SET_FLAG])
            next_alignedFlag = 1'b0;
        if (sysrefRealign)
            next_realignFlag = 1'b1;
        // Rearm on each enable; disabling drops the arm
        if (encEn && !encEnPrev)
            next_armed = 1'b1;
        else if (!encEn)
            next_armed = 1'b0;
        if (sysrefPhaseEvent && encEn && (armed || !encEnPrev))
        begin
            next_alignedFlag = 1'b1;
            next_armed = 1'b0;
        end
        next_irq = |({3'b000, next_realignFlag, next_alignedFlag, 3'b000}
            & irqMask);
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            realignFlag <= 1'b0;
            alignedFlag <= 1'b0;
            armed <= 1'b0;
            encEnPrev <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            realignFlag <= next_realignFlag;
            alignedFlag <= next_alignedFlag;
            armed <= next_armed;
            encEnPrev <= encEn;
            irq <= next_irq;
        end
    end

    // =========================================================
    // Bus answer: one wait cycle, then data with waitrequest low
    logic [7:0] statusWord;
    logic [7:0] rdByte;
    logic [31:0] next_avReadData;
    logic next_avWaitRequest;

    always_comb
    begin
        statusWord = 8'h00;
        statusWord[slsc_pkg::ST_LINK_UP] = linkUp;
        statusWord[slsc_pkg::ST_SYNC] = syncStat;
        statusWord[slsc_pkg::ST_REALIGN] = realignFlag;
        statusWord[slsc_pkg::ST_MULTIFRAME_PHASE_SET_FLAG] = alignedFlag;
        statusWord[slsc_pkg::ST_PLL] = lockStat;
        rdByte = 8'h00;
        if (hit(avAddress, slsc_pkg::IDX_STATUS))
            rdByte = statusWord;
        if (hit(avAddress, slsc_pkg::IDX_PWRDN))
            rdByte = pwrdn;
        if (hit(avAddress, slsc_pkg::IDX_SPARE_A))
            rdByte = spareA;
        if (hit(avAddress, slsc_pkg::IDX_SPARE_B))
            rdByte = spareB;
        if (hit(avAddress, slsc_pkg::IDX_IRQ_MASK))
            rdByte = irqMask;
        if (hit(avAddress, slsc_pkg::IDX_CTRL))
            rdByte = ctrl;
        if (hit(avAddress, slsc_pkg::IDX_FORMAT))
            rdByte = format;
        next_avReadData = avReadData;
        if (avRead && avWaitRequest)
            next_avReadData = {24'h000000, rdByte};
        next_avWaitRequest = ~(busReq & avWaitRequest);
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            avReadData <= 32'h00000000;
            avWaitRequest <= 1'b1;
        end
        else
        begin
            avReadData <= next_avReadData;
            avWaitRequest <= next_avWaitRequest;
        end
    end

    // =========================================================
    // Power and lane control
    slsc_lane_if #(.LANES(LANES)) lanesA ();
    slsc_lane_if #(.LANES(LANES)) lanesB ();

    logic pdA;
    logic pdB;
    logic allDown;

    assign pdA = pwrdn[slsc_pkg::PD_A];
    assign pdB = pwrdn[slsc_pkg::PD_B];
    assign allDown = pdA & pdB;
    // Link A survives a down A only if it also carries B
    assign lanesA.linkActive = ~allDown & (~pdA | linkAHoldsBoth);
    assign lanesB.linkActive = ~allDown & ~pdB;
    assign lanesA.spareEn = spareA[7:1];
    assign lanesA.serMode = spareA[slsc_pkg::SPARE_SER];
    assign lanesA.baseLanes = baseLanesA;
    assign lanesB.spareEn = spareB[7:1];
    assign lanesB.serMode = spareB[slsc_pkg::SPARE_SER];
    assign lanesB.baseLanes = baseLanesB;

    slsc_lane_gate #(.LANES(LANES)) gateA (.lanes(lanesA));
    slsc_lane_gate #(.LANES(LANES)) gateB (.lanes(lanesB));

    // Every control output is registered to keep it glitch free
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            converterAPowerdown <= 1'b0;
            converterBPowerdown <= 1'b0;
            digChanPowerDown <= 2'b00;
            serialSubsystemPowerDown <= 1'b0;
            slotBValid <= 1'b0;
            linkEncoderEnable <= 1'b0;
            linkFormatSelect <= '0;
            linkTestPatternSelect <= '0;
            laneClkEnA <= '0;
            serClkEnA <= '0;
            laneClkEnB <= '0;
            serClkEnB <= '0;
        end
        else
        begin
            converterAPowerdown <= pdA;
            converterBPowerdown <= pdB;
            for (int d = 0; d < 2; d++)
                digChanPowerDown[d] <= digBindB[d] ? pdB : pdA;
            serialSubsystemPowerDown <= allDown;
            slotBValid <= ~pdB;
            linkEncoderEnable <= encEn;
            // Spare lanes share these settings with regular lanes
            linkFormatSelect <= format[slsc_pkg::FORMAT_W-1:0];
            linkTestPatternSelect <=
                ctrl[slsc_pkg::CTRL_TEST_LSB +: slsc_pkg::TEST_W];
            laneClkEnA <= lanesA.laneClkEn;
            serClkEnA <= lanesA.serClkEn;
            laneClkEnB <= lanesB.laneClkEn;
            serClkEnB <= lanesB.serClkEn;
        end
    end

    // =========================================================
    // Assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    logic rdStatus;
    assign rdStatus = avRead & avWaitRequest & hit(avAddress, slsc_pkg::IDX_STATUS);

    link_up_a: assert property (rdStatus |=> avReadData[6] == $past(linkUp))
        else $error("link-up status bit wrong");
    sync_level_a: assert property (##3 syncStat == $past(syncN, 2))
        else $error("sync status does not follow pin");
    realign_set_a: assert property (sysrefRealign |=> realignFlag
        && (irq || !$past(irqMask[4])))
        else $error("realign flag not set");
    realign_clear_a: assert property (clrStatus && wdata[4] && !sysrefRealign
        |=> !realignFlag)
        else $error("realign flag not cleared");
    multiframe_phase_set_flag_set_a: assert property (sysrefPhaseEvent && armed && encEn |=> alignedFlag
        && !armed)
        else $error("multiframe_phase_set_flag flag not set");
    set_wins_a: assert property (clrStatus && wdata[3] && sysrefPhaseEvent && armed
        && encEn |=> alignedFlag)
        else $error("clear beat phase event");
    pll_lock_a: assert property (rdStatus |=> avReadData[2] == $past(lockStat))
        else $error("lock status bit wrong");
    chan_down_a: assert property (pdA && !digBindB[0] |=> converterAPowerdown
        && digChanPowerDown[0])
        else $error("channel A not powered down");
    all_down_a: assert property (allDown |=> serialSubsystemPowerDown && laneClkEnA == '0
        && laneClkEnB == '0)
        else $error("subsystem not powered down");
    pd_override_a: assert property (pdB && spareB[7:1] != '0 |=> laneClkEnB == '0)
        else $error("spare lane woke on dead link");
    ser_prefix_a: assert property (serClkEnA[3] |-> &laneClkEnA[3:0])
        else $error("serializer clocked without lower lanes");
    bus_wait_a: assert property (busReq && avWaitRequest |=> !avWaitRequest ##1
        avWaitRequest)
        else $error("bus answer timing wrong");

    spare_ser_c: cover property (serClkEnA[7] && !baseLanesA[7]);
    multiframe_phase_set_flag_c: cover property (sysrefPhaseEvent && armed && encEn ##1 irq);
    keep_a_c: cover property (pdA && linkAHoldsBoth && !pdB ##1 laneClkEnA != '0);
endmodule

// >>> pkg/slsc_pkg.sv
// Register map, field positions and reset values of the serial link
// status and lane control bank.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one register a word.
package slsc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_STATUS = 10'h208;
    localparam logic [9:0] IDX_PWRDN = 10'h209;
    localparam logic [9:0] IDX_SPARE_A = 10'h20a;
    localparam logic [9:0] IDX_SPARE_B = 10'h20b;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h20c;
    localparam logic [9:0] IDX_CTRL = 10'h20d;
    localparam logic [9:0] IDX_FORMAT = 10'h20e;
    // Status field positions
    localparam int ST_LINK_UP = 6;
    localparam int ST_SYNC = 5;
    localparam int ST_REALIGN = 4;
    localparam int ST_MULTIFRAME_PHASE_SET_FLAG = 3;
    localparam int ST_PLL = 2;
    // Power-down, spare-lane and control field positions
    localparam int PD_A = 0;
    localparam int PD_B = 1;
    localparam int SPARE_SER = 0;
    localparam int CTRL_ENC_EN = 0;
    localparam int CTRL_TEST_LSB = 4;
    localparam int FORMAT_W = 5;
    localparam int TEST_W = 4;
    // Reset values
    localparam logic [7:0] PWRDN_RST = 8'h00;
    localparam logic [7:0] SPARE_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] FORMAT_RST = 8'h00;
    // Writable bits of each register
    localparam logic [7:0] PWRDN_WMASK = 8'h03;
    localparam logic [7:0] STICKY_WMASK = 8'h18;
    localparam logic [7:0] CTRL_WMASK = 8'hf1;
    localparam logic [7:0] FORMAT_WMASK = 8'h1f;
endpackage

// >>> pkg/slsc_lane_if.sv
// Lane gating bundle between the register bank and one lane gate.
// Assumes both ends sit on the same clock; the bundle is combinational.
`timescale 1ns/100ps
interface slsc_lane_if #(parameter int LANES = 8);
    logic [LANES-1:1] spareEn;
    logic serMode;
    logic [LANES-1:0] baseLanes;
    logic linkActive;
    logic [LANES-1:0] laneClkEn;
    logic [LANES-1:0] serClkEn;
    modport ctrl (output spareEn, serMode, baseLanes, linkActive,
        input laneClkEn, serClkEn);
    modport gate (input spareEn, serMode, baseLanes, linkActive,
        output laneClkEn, serClkEn);
endinterface

// >>> core/slsc_lane_gate.sv
// Lane clock and serializer clock gating for one link.
// Assumes the caller registers the results before they leave the chip.
`timescale 1ns/100ps
module slsc_lane_gate #(
    parameter int LANES = 8
)(
    slsc_lane_if.gate lanes
);
    // =========================================================
    // Elaboration check
    if (LANES < 2 || LANES > 8)
    begin : g_bad_lanes
        $error("slsc_lane_gate: LANES must be 2 to 8");
    end

    // =========================================================
    // Gating; a serializer also needs every lower lane running
    always_comb
    begin
        logic [LANES-1:0] want;
        logic prefix;
        want = lanes.baseLanes | {lanes.spareEn, 1'b0};
        prefix = 1'b1;
        for (int n = 0; n < LANES; n++)
        begin
            lanes.laneClkEn[n] = lanes.linkActive & want[n];
            prefix = prefix & want[n];
            // Spare lanes serialize only in serializer mode
            lanes.serClkEn[n] = lanes.linkActive & prefix
                & (lanes.baseLanes[n] | lanes.serMode);
        end
    end
endmodule

// >>> verif/slsc_rx_model.sv
// Receiver-side model of the serial link: SYNC~ request and link-up level.
// Assumes the encoder enable comes from the register bank on mclk.
`timescale 1ns/100ps
module slsc_rx_model #(
    parameter int HOLD = 20
)(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic encEn,
    output logic syncN,
    output logic linkUp
);
    int count;

    // =========================================
    // Sync request
    // Held low for HOLD cycles after the encoder starts, like a slow receiver
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= 0;
        end
        else if (!encEn)
        begin
            count <= 0;
        end
        else if (count < HOLD)
        begin
            count <= count + 1;
        end
    end

    // Link counts as up once the request is released
    assign syncN = (count == HOLD);
    assign linkUp = syncN;
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the serial link status and lane control bank.
// Assumes the bank answers on Avalon-MM and the receiver model drives SYNC~.
`timescale 1ns/100ps
module testbench;
    localparam logic [11:0] A_ST = {slsc_pkg::IDX_STATUS, 2'b00};
    localparam logic [11:0] A_PD = {slsc_pkg::IDX_PWRDN, 2'b00};
    localparam logic [11:0] A_SA = {slsc_pkg::IDX_SPARE_A, 2'b00};
    localparam logic [11:0] A_SB = {slsc_pkg::IDX_SPARE_B, 2'b00};
    localparam logic [11:0] A_MK = {slsc_pkg::IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_CT = {slsc_pkg::IDX_CTRL, 2'b00};
    localparam logic [11:0] A_FM = {slsc_pkg::IDX_FORMAT, 2'b00};
    // Power-down steps: written value, packed view, lane clocks of A and B
    localparam logic [7:0] PD_IN [4] = '{8'h01, 8'h02, 8'hff, 8'h00};
    localparam logic [7:0] PD_VIEW [4] = '{8'h54, 8'ha0, 8'hf8, 8'h04};
    localparam logic [7:0] LANE_A [4] = '{8'h0b, 8'h0b, 8'h00, 8'h0b};
    localparam logic [7:0] LANE_B [4] = '{8'h0b, 8'h00, 8'h00, 8'h0b};
    logic mclk;
    logic nrst;
    logic [11:0] avAddress;
    logic avRead;
    logic avWrite;
    logic [31:0] avWriteData;
    logic [3:0] avByteEnable;
    logic [31:0] avReadData;
    logic avWaitRequest;
    logic irq;
    logic linkUp;
    logic syncN;
    logic synthLockedPin;
    logic sysrefRealign;
    logic sysrefPhaseEvent;
    logic [7:0] baseLanesA;
    logic [7:0] baseLanesB;
    logic linkAHoldsBoth;
    logic [1:0] digBindB;
    logic converterAPowerdown;
    logic converterBPowerdown;
    logic [1:0] digChanPowerDown;
    logic serialSubsystemPowerDown;
    logic slotBValid;
    logic linkEncoderEnable;
    logic [4:0] linkFormatSelect;
    logic [3:0] linkTestPatternSelect;
    logic [7:0] laneClkEnA;
    logic [7:0] serClkEnA;
    logic [7:0] laneClkEnB;
    logic [7:0] serClkEnB;
    logic [7:0] pwrView;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;

    // Power and interrupt outputs packed into one byte for compact compares
    assign pwrView = {converterBPowerdown, converterAPowerdown, digChanPowerDown,
        serialSubsystemPowerDown, slotBValid, linkEncoderEnable, irq};

    slsc_regs #(.LANES(8)) DUT (.mclk, .nrst, .avAddress, .avRead, .avWrite,
        .avWriteData, .avByteEnable, .avReadData, .avWaitRequest, .irq, .linkUp,
        .syncN, .synthLockedPin, .sysrefRealign, .sysrefPhaseEvent, .baseLanesA,
        .baseLanesB, .linkAHoldsBoth, .digBindB, .converterAPowerdown,
        .converterBPowerdown, .digChanPowerDown, .serialSubsystemPowerDown,
        .slotBValid, .linkEncoderEnable, .linkFormatSelect, .linkTestPatternSelect,
        .laneClkEnA, .serClkEnA, .laneClkEnB, .serClkEnB);

    slsc_rx_model #(.HOLD(20)) partner (.mclk, .nrst, .encEn(linkEncoderEnable),
        .syncN, .linkUp);

    // =========================================
    // Clock and hang guard
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // A few hundred cycles are needed; far beyond that means a hang
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    // =========================================
    // Tasks
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One bus cycle; must be entered right after a rising edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [31:0] q);
        avAddress <= a;
        avWrite <= w;
        avRead <= !w;
        avWriteData <= {24'h000000, d};
        do
            @(posedge mclk);
        while (avWaitRequest !== 1'b0);
        q = avReadData;
        avRead <= 1'b0;
        avWrite <= 1'b0;
        // Extra edge so the next request never lands in the same step
        @(posedge mclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q[7:0], e);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    // Registered outputs lag a write by one edge
    task automatic settle();
        repeat (2) @(posedge mclk);
    endtask

    task automatic pulse(input logic phase);
        if (phase)
            sysrefPhaseEvent <= 1'b1;
        else
            sysrefRealign <= 1'b1;
        @(posedge mclk);
        sysrefPhaseEvent <= 1'b0;
        sysrefRealign <= 1'b0;
        @(posedge mclk);
    endtask

    // =========================================
    // Main sequence
    initial
    begin
        nrst = 1'b0;
        avAddress = 12'h000;
        avRead = 1'b0;
        avWrite = 1'b0;
        avWriteData = 32'h00000000;
        avByteEnable = 4'hf;
        synthLockedPin = 1'b1;
        sysrefRealign = 1'b0;
        sysrefPhaseEvent = 1'b0;
        baseLanesA = 8'h01;
        baseLanesB = 8'h03;
        linkAHoldsBoth = 1'b0;
        digBindB = 2'b10;
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        // Reset state; encoder off, so SYNC~ held and link down
        rd(A_PD, 8'h00);
        rd(A_SA, 8'h00);
        rd(A_SB, 8'h00);
        rd(A_ST, 8'h04);
        chk(pwrView, 8'h04);
        // Spare lanes while the encoder is off
        wr(A_SA, 8'hfe);
        wr(A_SB, 8'h09);
        settle();
        chk(laneClkEnA, 8'hff);
        chk(serClkEnA, 8'h01);
        chk(laneClkEnB, 8'h0b);
        chk(serClkEnB, 8'h03);
        // Gap at lane 2 starves serializer 3
        wr(A_SA, 8'h0b);
        settle();
        chk(laneClkEnA, 8'h0b);
        chk(serClkEnA, 8'h03);
        rd(A_SA, 8'h0b);
        // Power-down steps, link A carrying both channels
        // Both bits at once only to reach the shutdown path
        linkAHoldsBoth <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wr(A_PD, PD_IN[i]);
            settle();
            rd(A_PD, PD_IN[i] & 8'h03);
            chk(pwrView, PD_VIEW[i]);
            chk(laneClkEnA, LANE_A[i]);
            chk(laneClkEnB, LANE_B[i]);
        end
        // Link A alone stops with converter A
        linkAHoldsBoth <= 1'b0;
        wr(A_PD, 8'h01);
        settle();
        chk(laneClkEnA, 8'h00);
        chk(laneClkEnB, 8'h0b);
        wr(A_PD, 8'h00);
        // Shared format and pattern settings
        wr(A_CT, 8'h70);
        wr(A_FM, 8'hff);
        settle();
        chk({4'h0, linkTestPatternSelect}, 8'h07);
        chk({3'h0, linkFormatSelect}, 8'h1f);
        wr(A_CT, 8'h00);
        // Realignment flag, interrupt and clear
        pulse(1'b0);
        rd(A_ST, 8'h14);
        chk(pwrView, 8'h04);
        wr(A_MK, 8'h18);
        settle();
        chk(pwrView, 8'h05);
        wr(A_ST, 8'hff);
        settle();
        rd(A_ST, 8'h04);
        chk(pwrView, 8'h04);
        // Clear and set on the same edge: set wins
        fork
            wr(A_ST, 8'h10);
            begin
                @(posedge mclk);
                sysrefRealign <= 1'b1;
                @(posedge mclk);
                sysrefRealign <= 1'b0;
            end
        join
        rd(A_ST, 8'h14);
        wr(A_ST, 8'h10);
        // Multiframe phase flag, once per encoder enable
        wr(A_CT, 8'h01);
        settle();
        pulse(1'b1);
        rd(A_ST, 8'h0c);
        chk(pwrView, 8'h07);
        repeat (40) @(posedge mclk);
        rd(A_ST, 8'h6c);
        wr(A_ST, 8'h08);
        pulse(1'b1);
        rd(A_ST, 8'h64);
        wr(A_CT, 8'h00);
        // SYNC~ status trails the pin by two more edges
        repeat (4) @(posedge mclk);
        rd(A_ST, 8'h04);
        // Re-enable rearms; event on the clearing edge still sets
        wr(A_CT, 8'h01);
        settle();
        fork
            wr(A_ST, 8'h08);
            begin
                @(posedge mclk);
                sysrefPhaseEvent <= 1'b1;
                @(posedge mclk);
                sysrefPhaseEvent <= 1'b0;
            end
        join
        rd(A_ST, 8'h0c);
        wr(A_ST, 8'h08);
        wr(A_CT, 8'h00);
        // Synthesizer lock loss
        synthLockedPin <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(A_ST, 8'h00);
        synthLockedPin <= 1'b1;
        // Unmapped address and disabled byte lane are ignored
        wr(12'h900, 8'hff);
        rd(12'h900, 8'h00);
        avByteEnable <= 4'he;
        wr(A_PD, 8'h03);
        avByteEnable <= 4'hf;
        rd(A_PD, 8'h00);
        end_of_test();
    end
endmodule
